// *** sofr_pkg.sv ***
// Shared constants and types for the serial flash security region link
package sofr_pkg;
  // Opcodes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] OP_OTP_PROGRAM  = 8'h9b;
  localparam logic [7:0] OP_OTP_READ     = 8'h77;
  // Region geometry
  localparam int REGION_BYTES = 128;
  localparam int USER_BYTES   = 64;
  localparam int BUF_BYTES    = 256;
  localparam int ADDR_BYTES   = 3;
  localparam int DUMMY_BYTES  = 2;
  localparam int STATUS_BYTES = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // Status byte fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEL_BIT  = 1;
  // Timing
  localparam int CLK_PERIOD_NS             = 8;
  localparam int OTP_PROGRAM_DURATION_US   = 1000;
  localparam int SCK_HALF_CYCLES_DEFAULT   = 4;
  // Arbitrary seed for the per-part factory pattern
  localparam logic [7:0] FACTORY_SEED_DEFAULT = 8'h5a;

  typedef enum logic [2:0] {
    DS_OPCODE, DS_ADDR, DS_DUMMY, DS_PROG_DATA, DS_READ_DATA, DS_STATUS, DS_SKIP
  } sofr_dev_st_t;

  typedef enum logic [2:0] {
    HS_IDLE, HS_LOAD, HS_LOW, HS_HIGH, HS_END
  } sofr_host_st_t;
endpackage : sofr_pkg

// *** sofr_link_if.sv ***
// Serial link between host controller and flash security region logic
`timescale 1ns/10ps
`default_nettype none
interface sofr_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev  (input cs_n, input sck, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, input miso, input miso_oe);
endinterface : sofr_link_if
`default_nettype wire

// *** sofr_pair_buf.sv ***
// Small shifting buffer with valid/ready on both sides, outputs from flops
`timescale 1ns/10ps
`default_nettype none
module sofr_pair_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] mem [DEPTH];
  logic [DEPTH-1:0] vld;
  wire pop  = vld[0] & out_ready_i;
  wire push = in_valid_i & in_ready_o;
  logic [DEPTH-1:0] shifted;
  // Entry below slot i is occupied; slot 0 always has a floor
  wire  [DEPTH:0]   below = {shifted, 1'b1};

  assign in_ready_o  = ~vld[DEPTH-1];
  assign out_valid_o = vld[0];
  assign out_data_o  = mem[0];
  assign shifted     = pop ? (vld >> 1) : vld;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vld <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (pop && i < DEPTH - 1)
          mem[i] <= mem[i+1];
        if (push && !shifted[i] && below[i])
          mem[i] <= in_data_i;
      end
      vld <= (push ? {shifted[DEPTH-2:0], 1'b1} : shifted);
    end
  end
endmodule : sofr_pair_buf
`default_nettype wire

// *** sofr_device.sv ***
// Flash-side command logic for the one-time-programmable security region
//
// Overview of operation
// - 128-byte region: 64 user bytes, 64 factory
// - Programmed user half never erased or reprogrammed
// - Factory half fixed per part, never altered
// - One program pass locks whole user half
// - Program needs write enable latch set first
// - Program: 9Bh, three address bytes, data bytes
// - Program start uses only low six bits
// - Data wraps past 63; unsent bytes stay erased
// - Over 64 bytes keeps only last 64
// - Chip select rise writes buffered bytes
// - Program cycle self-timed within program duration
// - Short frame or misaligned release aborts program
// - Aborted program clears write enable latch
// - Busy reported; latch cleared before completion
// - Power loss mid-program leaves half locked
// - Program uses shared 256-byte buffer
// - Read: 77h, address, two dummies, then data
// - Read wraps 7Fh to 00h without delay
// - Chip select rise ends read, output released
// - 06h on byte boundary sets latch
// - 05h alternates status and 00h bytes: busy bit0, latch bit1
`timescale 1ns/10ps
`default_nettype none
module sofr_device
  import sofr_pkg::*;
#(
  parameter int         OTPP_US      = OTP_PROGRAM_DURATION_US,
  parameter logic [7:0] FACTORY_SEED = FACTORY_SEED_DEFAULT
) (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  input  wire logic factory_init_i,
  sofr_link_if.dev  link,
  output logic      busy_o,
  output logic      write_enable_latch_o,
  output logic      locked_o
);
  localparam int OTPP_CYCLES = (OTPP_US * 1000) / CLK_PERIOD_NS;

  // Per-part pattern, fixed in logic so no command can reach it
  function automatic logic [7:0] factory_byte(input logic [5:0] idx);
    factory_byte = FACTORY_SEED ^ 8'({idx, 2'b01} * 8'h3b);
  endfunction : factory_byte

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0] user_mem [USER_BYTES];   // Nonvolatile, untouched by reset
  logic       locked;                  // Nonvolatile programmed flag
  logic [7:0] data_buf [BUF_BYTES];
  logic [USER_BYTES-1:0] fill_mask;

  // ------------------------------------------------------------
  // Link decode
  // ------------------------------------------------------------
  sofr_dev_st_t state;
  logic       sck_q;
  logic       cs_q;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic [1:0] hdr_cnt;
  logic [23:0] addr;
  logic       is_prog;
  logic       got_data;
  logic       wren_pend;
  logic [5:0] wptr;
  logic [6:0] rptr;
  logic       stat_sel;
  logic [6:0] oshift;
  logic       miso;
  logic       miso_oe;
  logic       write_enable_latch;
  logic       busy;
  logic [31:0] pcnt;

  wire        rise      = link.sck & ~sck_q & ~link.cs_n;
  wire        fall      = ~link.sck & sck_q & ~link.cs_n;
  wire        cs_end    = link.cs_n & ~cs_q;
  wire [7:0]  next_byte = {shreg[6:0], link.mosi};
  wire        byte_done = rise && bit_cnt == 3'h7;
  wire [23:0] next_addr = {addr[15:0], next_byte};
  wire        out_phase = (state == DS_READ_DATA) || (state == DS_STATUS);
  wire        load_out  = fall && out_phase && bit_cnt == 3'h0;
  wire [7:0]  stat_byte = stat_sel ? 8'h00 : 8'((32'(write_enable_latch) << STAT_WEL_BIT) | (32'(busy) << STAT_BUSY_BIT));
  wire [7:0]  region_byte = rptr[6] ? factory_byte(rptr[5:0]) : user_mem[rptr[5:0]];
  wire [7:0]  out_src   = (state == DS_STATUS) ? stat_byte : region_byte;
  wire        prog_ok   = got_data && bit_cnt == 3'h0 && !locked;
  wire        prog_abort = cs_end && is_prog &&
                           (state == DS_ADDR || (state == DS_PROG_DATA && !prog_ok));
  wire        prog_start = cs_end && state == DS_PROG_DATA && prog_ok;
  wire        prog_end  = busy && pcnt == 32'(OTPP_CYCLES - 1);

  assign link.miso            = miso;
  assign link.miso_oe         = miso_oe;
  assign busy_o               = busy;
  assign write_enable_latch_o = write_enable_latch;
  assign locked_o             = locked;

  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state     <= DS_OPCODE;
      sck_q     <= 1'b0;
      cs_q      <= 1'b1;
      bit_cnt   <= 3'h0;
      shreg     <= 8'h00;
      hdr_cnt   <= 2'h0;
      addr      <= 24'h000000;
      is_prog   <= 1'b0;
      got_data  <= 1'b0;
      wren_pend <= 1'b0;
    end else if (ce_i) begin
      sck_q <= link.sck;
      cs_q  <= link.cs_n;
      if (link.cs_n) begin
        state     <= DS_OPCODE;
        bit_cnt   <= 3'h0;
        hdr_cnt   <= 2'h0;
        is_prog   <= 1'b0;
        got_data  <= 1'b0;
        wren_pend <= 1'b0;
      end else if (rise) begin
        shreg   <= next_byte;
        bit_cnt <= bit_cnt + 3'h1;
        if (byte_done) begin
          case (state)
            DS_OPCODE: begin
              case (next_byte)
                OP_WRITE_ENABLE: begin
                  wren_pend <= !busy;
                  state     <= DS_SKIP;
                end
                OP_READ_STATUS:  state <= DS_STATUS;
                OP_OTP_PROGRAM: begin
                  is_prog <= !busy && write_enable_latch;
                  state   <= (!busy && write_enable_latch) ? DS_ADDR : DS_SKIP;
                end
                OP_OTP_READ:     state <= busy ? DS_SKIP : DS_ADDR;
                default:         state <= DS_SKIP;
              endcase
            end
            DS_ADDR: begin
              addr    <= next_addr;
              hdr_cnt <= hdr_cnt + 2'h1;
              if (hdr_cnt == 2'(ADDR_BYTES - 1)) begin
                hdr_cnt <= 2'h0;
                state   <= is_prog ? DS_PROG_DATA : DS_DUMMY;
              end
            end
            DS_DUMMY: begin
              hdr_cnt <= hdr_cnt + 2'h1;
              if (hdr_cnt == 2'(DUMMY_BYTES - 1))
                state <= DS_READ_DATA;
            end
            DS_PROG_DATA: got_data <= 1'b1;
            default: ;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Program data capture into the shared buffer
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fill_mask <= '0;
      wptr      <= 6'h00;
    end else if (ce_i) begin
      if (state == DS_ADDR && byte_done && is_prog && hdr_cnt == 2'(ADDR_BYTES - 1)) begin
        wptr      <= next_addr[5:0];
        fill_mask <= '0;
      end else if (state == DS_PROG_DATA && byte_done) begin
        // Same slot reused every 64 bytes, so the last 64 survive
        data_buf[{2'b00, wptr}] <= next_byte;
        fill_mask[wptr]         <= 1'b1;
        wptr                    <= wptr + 6'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // Serial output for region and status reads
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      miso     <= 1'b0;
      miso_oe  <= 1'b0;
      oshift   <= 7'h00;
      rptr     <= 7'h00;
      stat_sel <= 1'b0;
    end else if (ce_i) begin
      if (link.cs_n) begin
        miso_oe  <= 1'b0;
        stat_sel <= 1'b0;
      end else if (state == DS_ADDR && byte_done && hdr_cnt == 2'(ADDR_BYTES - 1)) begin
        rptr <= next_addr[6:0];
      end else if (load_out) begin
        miso    <= out_src[7];
        oshift  <= out_src[6:0];
        miso_oe <= 1'b1;
        if (state == DS_READ_DATA)
          rptr <= rptr + 7'h01;
        else
          stat_sel <= ~stat_sel;
      end else if (fall && out_phase) begin
        miso   <= oshift[6];
        oshift <= {oshift[5:0], 1'b0};
      end
    end
  end

  // ------------------------------------------------------------
  // Write enable latch and self-timed program cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      write_enable_latch  <= 1'b0;
      busy <= 1'b0;
      pcnt <= 32'h0;
    end else if (ce_i) begin
      if (prog_abort || prog_start)
        write_enable_latch <= 1'b0;
      else if (cs_end && wren_pend && bit_cnt == 3'h0)
        write_enable_latch <= 1'b1;
      if (prog_start) begin
        busy <= 1'b1;
        pcnt <= 32'h0;
      end else if (busy) begin
        pcnt <= pcnt + 32'h1;
        if (prog_end)
          busy <= 1'b0;
      end
    end
  end

  // Lock is set before any byte is written, so a cut supply leaves it set
  always_ff @(posedge clk_i) begin
    if (factory_init_i) begin
      locked <= 1'b0;
      for (int i = 0; i < USER_BYTES; i++)
        user_mem[i] <= ERASED_BYTE;
    end else if (ce_i) begin
      if (prog_start)
        locked <= 1'b1;
      if (busy && pcnt < 32'(USER_BYTES) && fill_mask[pcnt[5:0]])
        user_mem[pcnt[5:0]] <= data_buf[{2'b00, pcnt[5:0]}];
    end
  end
endmodule : sofr_device
`default_nettype wire

// *** sofr_host.sv ***
// Host-side controller that frames commands on the serial link
`timescale 1ns/10ps
`default_nettype none
module sofr_host
  import sofr_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYCLES_DEFAULT,
  parameter int LEN_W    = 9
) (
  input  wire logic             clk_i,
  input  wire logic             reset_i,
  input  wire logic             ce_i,
  input  wire logic             cmd_valid_i,
  output logic                  cmd_ready_o,
  input  wire logic [7:0]       cmd_op_i,
  input  wire logic [23:0]      cmd_addr_i,
  input  wire logic [LEN_W-1:0] cmd_len_i,
  input  wire logic [7:0]       wr_data_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  output logic [7:0]            rd_data_o,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic                  done_o,
  sofr_link_if.host             link
);
  function automatic logic [7:0] hdr_byte(input logic [7:0] op, input logic [23:0] a, input logic [LEN_W:0] i);
    case (i)
      0:       hdr_byte = op;
      1:       hdr_byte = a[23:16];
      2:       hdr_byte = a[15:8];
      3:       hdr_byte = a[7:0];
      default: hdr_byte = 8'h00;
    endcase
  endfunction : hdr_byte

  sofr_host_st_t state;
  logic [7:0]   op;
  logic [23:0]  addr;
  logic [LEN_W:0] total;
  logic [LEN_W:0] idx;
  logic [7:0]   tx;
  logic [7:0]   rx;
  logic [2:0]   bit_cnt;
  logic [15:0]  tick;
  logic         push;
  logic         cs_n;
  logic         sck;
  logic         mosi;
  logic         buf_ready;

  wire is_prog = cmd_op_i == OP_OTP_PROGRAM;
  wire [LEN_W:0] hdr_n = is_prog ? (LEN_W+1)'(1 + ADDR_BYTES) :
                         (cmd_op_i == OP_OTP_READ) ? (LEN_W+1)'(1 + ADDR_BYTES + DUMMY_BYTES) : (LEN_W+1)'(1);
  // A program frame always carries at least one data byte
  wire [LEN_W:0] data_n = (cmd_op_i == OP_WRITE_ENABLE) ? '0 :
                          (is_prog && cmd_len_i == '0) ? (LEN_W+1)'(1) : {1'b0, cmd_len_i};
  wire [LEN_W:0] op_hdr = (op == OP_OTP_PROGRAM) ? (LEN_W+1)'(1 + ADDR_BYTES) :
                          (op == OP_OTP_READ) ? (LEN_W+1)'(1 + ADDR_BYTES + DUMMY_BYTES) : (LEN_W+1)'(1);
  wire in_data   = idx >= op_hdr;
  wire rx_phase  = in_data && (op == OP_OTP_READ || op == OP_READ_STATUS);
  wire wr_phase  = in_data && op == OP_OTP_PROGRAM;
  wire half_done = tick == 16'(SCK_HALF - 1);
  wire last_byte = idx == total - (LEN_W+1)'(1);
  wire [7:0] hdr_cur = hdr_byte(op, addr, idx);

  assign link.cs_n = cs_n;
  assign link.sck  = sck;
  assign link.mosi = mosi;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state       <= HS_IDLE;
      cmd_ready_o <= 1'b0;
      wr_ready_o  <= 1'b0;
      done_o      <= 1'b0;
      cs_n        <= 1'b1;
      sck         <= 1'b0;
      mosi        <= 1'b0;
      push        <= 1'b0;
      op          <= 8'h00;
      addr        <= 24'h0;
      total       <= '0;
      idx         <= '0;
      tx          <= 8'h00;
      rx          <= 8'h00;
      bit_cnt     <= 3'h0;
      tick        <= 16'h0;
    end else if (ce_i) begin
      done_o <= 1'b0;
      push   <= 1'b0;
      tick   <= tick + 16'h1;
      case (state)
        HS_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o <= 1'b0;
            op    <= cmd_op_i;
            addr  <= cmd_addr_i;
            total <= hdr_n + data_n;
            idx   <= '0;
            cs_n  <= 1'b0;
            state <= HS_LOAD;
          end
        end
        HS_LOAD: begin
          tick <= 16'h0;
          if (wr_phase) begin
            wr_ready_o <= 1'b1;
            if (wr_ready_o && wr_valid_i) begin
              wr_ready_o <= 1'b0;
              tx    <= wr_data_i;
              mosi  <= wr_data_i[7];
              state <= HS_LOW;
            end
          end else if (!rx_phase || (buf_ready && !push)) begin
            // Holding the clock here is how a stalled reader throttles the link
            tx    <= hdr_cur;
            mosi  <= hdr_cur[7];
            state <= HS_LOW;
          end
        end
        HS_LOW: if (half_done) begin
          tick  <= 16'h0;
          sck   <= 1'b1;
          rx    <= {rx[6:0], link.miso};
          state <= HS_HIGH;
        end
        HS_HIGH: if (half_done) begin
          tick <= 16'h0;
          sck  <= 1'b0;
          tx   <= {tx[6:0], 1'b0};
          mosi <= tx[6];
          bit_cnt <= bit_cnt + 3'h1;
          state   <= HS_LOW;
          if (bit_cnt == 3'h7) begin
            push  <= rx_phase;
            idx   <= idx + (LEN_W+1)'(1);
            state <= last_byte ? HS_END : HS_LOAD;
          end
        end
        HS_END: if (half_done) begin
          cs_n   <= 1'b1;
          done_o <= 1'b1;
          state  <= HS_IDLE;
        end
        default: state <= HS_IDLE;
      endcase
    end
  end

  sofr_pair_buf #(.W(8), .DEPTH(2)) u_rx_buf (
    .clk_i       (clk_i),
    .reset_i     (reset_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   (rx),
    .out_valid_o (rd_valid_o),
    .out_ready_i (rd_ready_i),
    .out_data_o  (rd_data_o)
  );
endmodule : sofr_host
`default_nettype wire

// *** sofr_link_properties.sv ***
// Concurrent checks on the serial link between host and security region logic
`timescale 1ns/10ps
`default_nettype none
module sofr_link_properties #(
  parameter int OTPP_US = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic busy_o,
  input wire logic write_enable_latch_o
);
  // ------------------------------------------------------------
  // Program cycle counter
  // ------------------------------------------------------------
  // One clock of slack each way: start edge detection may shift by a cycle
  localparam int OTPP_CYC = OTPP_US * 125;
  int unsigned busy_cnt;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  always_ff @(posedge clk_i) begin
    if (reset_i || !busy_o) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  property p_busy_len;
    $fell(busy_o) |-> (busy_cnt + 1 >= OTPP_CYC) && (busy_cnt <= OTPP_CYC + 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("program cycle length off");

  property p_busy_start;
    $rose(busy_o) |-> cs_n && !write_enable_latch_o;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("program start not at frame end");

  property p_busy_wel;
    busy_o |-> !write_enable_latch_o;
  endproperty
  a_busy_wel: assert property (p_busy_wel) else $error("latch set while programming");

  property p_wel_set;
    $rose(write_enable_latch_o) |-> cs_n && !busy_o;
  endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch set inside a frame");

  property p_oe_idle;
    cs_n && $past(cs_n) && $past(cs_n, 2) |-> !miso_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");

  property p_oe_rise;
    $rose(miso_oe) |-> !cs_n;
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("output enabled outside a frame");

  property p_sck_idle;
    cs_n && $past(cs_n) |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock not low between frames");

  property p_miso_stable;
    !cs_n && miso_oe && sck && $past(sck) |-> $stable(miso);
  endproperty
  a_miso_stable: assert property (p_miso_stable) else $error("data changed while clock high");
endmodule : sofr_link_properties
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench: host and device joined, plus a rule-breaking driver on a second link
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import sofr_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        factory_init_i = 1'b1;
  logic        cmd_valid_i = 1'b0;
  logic [7:0]  cmd_op_i = 8'h00;
  logic [23:0] cmd_addr_i = 24'h000000;
  logic [8:0]  cmd_len_i = 9'h000;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_valid_i = 1'b0;
  logic        rd_ready_i = 1'b0;
  logic        cmd_ready_o, wr_ready_o, rd_valid_o, done_o;
  logic [7:0]  rd_data_o;
  logic        busy_o, write_enable_latch_o, locked_o, busy2, wel2, locked2;
  logic [7:0]  exp_mem [REGION_BYTES];
  logic [7:0]  wrq [$];
  logic [7:0]  rdq [$];
  int          errors = 0;
  int          num_checks = 0;
  int          stall = 0;

  sofr_link_if link_main ();
  sofr_link_if link_bad ();

  sofr_device #(.OTPP_US(2)) u_sofr_device (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .factory_init_i(factory_init_i), .link(link_main), .busy_o(busy_o),
    .write_enable_latch_o(write_enable_latch_o), .locked_o(locked_o));
  sofr_device #(.OTPP_US(2)) u_sofr_device_2 (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i),
    .factory_init_i(factory_init_i), .link(link_bad), .busy_o(busy2),
    .write_enable_latch_o(wel2), .locked_o(locked2));
  sofr_host u_sofr_host (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_len_i(cmd_len_i),
    .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .rd_ready_i(rd_ready_i), .done_o(done_o), .link(link_main));
  sofr_link_properties #(.OTPP_US(2)) u_sofr_link_properties (.clk_i(clk_i), .reset_i(reset_i),
    .cs_n(link_main.cs_n), .sck(link_main.sck), .miso(link_main.miso), .miso_oe(link_main.miso_oe),
    .busy_o(busy_o), .write_enable_latch_o(write_enable_latch_o));

  always #4 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // ------------------------------------------------------------
  // Host command port transfers, entered at a falling edge
  // ------------------------------------------------------------
  task automatic txn(input logic [7:0] op, input logic [23:0] a, input int n);
    int wi;
    bit tk;
    wi = 0;
    rdq.delete();
    cmd_op_i = op;
    cmd_addr_i = a;
    cmd_len_i = n[8:0];
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    cmd_valid_i = 1'b0;
    for (int k = 0; k < 30000; k++) begin
      if (done_o === 1'b1) break;
      // Drives first, then note what the coming rising edge takes
      wr_valid_i = (wi < wrq.size());
      wr_data_i = (wi < wrq.size()) ? wrq[wi] : 8'h00;
      rd_ready_i = (k >= stall);
      if (rd_valid_o === 1'b1 && rd_ready_i) rdq.push_back(rd_data_o);
      tk = wr_valid_i && wr_ready_o === 1'b1;
      @(negedge clk_i);
      if (tk) wi++;
    end
    // Up to two bytes may still sit in the host buffer after the frame ends
    wr_valid_i = 1'b0;
    rd_ready_i = 1'b1;
    repeat (6) begin
      if (rd_valid_o === 1'b1) rdq.push_back(rd_data_o);
      @(negedge clk_i);
    end
    rd_ready_i = 1'b0;
    // Stale program data must not ride along with the next command
    wrq.delete();
  endtask : txn

  task automatic stat(input logic [7:0] e);
    txn(OP_READ_STATUS, 24'h000000, STATUS_BYTES);
    chk8("status", e, rdq[0]);
    chk8("status2", 8'h00, rdq[1]);
  endtask : stat

  task automatic wait_idle;
    for (int i = 0; i < 10; i++) begin
      txn(OP_READ_STATUS, 24'h000000, 1);
      if (rdq[0] === 8'h00) break;
    end
  endtask : wait_idle

  task automatic prog(input logic [23:0] a, input int n, input logic [7:0] b, input bit ok);
    wrq.delete();
    for (int i = 0; i < n; i++) begin
      wrq.push_back(b + i[7:0]);
      if (ok && i >= n - USER_BYTES) exp_mem[(a[5:0] + i) % USER_BYTES] = b + i[7:0];
    end
    txn(OP_OTP_PROGRAM, a, n);
  endtask : prog

  task automatic rdall(input logic [23:0] a, input int n);
    txn(OP_OTP_READ, a, n);
    chk1("count", 1'b1, rdq.size() == n);
    for (int i = 0; i < n; i++) chk8("region", exp_mem[(a[6:0] + i) % REGION_BYTES], rdq[i]);
  endtask : rdall

  task automatic fresh_part;
    logic [7:0] t;
    factory_init_i = 1'b1;
    @(negedge clk_i);
    factory_init_i = 1'b0;
    for (int i = 0; i < REGION_BYTES; i++) begin
      t = {i[5:0], 2'b01};
      exp_mem[i] = (i < USER_BYTES) ? ERASED_BYTE : (FACTORY_SEED_DEFAULT ^ (t * 8'h3b));
    end
  endtask : fresh_part

  // Bit-level frames on the second link; released data line shows the inverse
  task automatic bb(input logic [63:0] v, input int nb);
    link_bad.cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      link_bad.mosi = v[63 - i];
      repeat (4) @(negedge clk_i);
      link_bad.sck = 1'b1;
      repeat (4) @(negedge clk_i);
      link_bad.sck = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    link_bad.cs_n = 1'b1;
    link_bad.mosi = ~link_bad.mosi;
    repeat (8) @(negedge clk_i);
  endtask : bb

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    link_bad.cs_n = 1'b1;
    link_bad.sck = 1'b0;
    link_bad.mosi = 1'b0;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    fresh_part();
    stat(8'h00);
    prog(24'h000000, 2, 8'h20, 1'b0);
    chk1("locked", 1'b0, locked_o);
    txn(OP_WRITE_ENABLE, 24'h000000, 0);
    stat(8'h02);
    prog(24'habcd3e, 3, 8'h10, 1'b1);
    stat(8'h01);
    wait_idle();
    chk1("locked", 1'b1, locked_o);
    rdall(24'h00007f, 130);
    $display("test first_program done");
    txn(OP_WRITE_ENABLE, 24'h000000, 0);
    prog(24'h000000, 1, 8'h80, 1'b0);
    stat(8'h00);
    reset_i = 1'b1;
    repeat (12) @(negedge clk_i);
    reset_i = 1'b0;
    chk1("locked", 1'b1, locked_o);
    rdall(24'h000000, 64);
    $display("test reprogram_refused done");
    fresh_part();
    txn(OP_WRITE_ENABLE, 24'h000000, 0);
    prog(24'h000005, 66, 8'h40, 1'b1);
    wait_idle();
    stall = 400;
    rdall(24'h000000, 128);
    stall = 0;
    $display("test overlong_program done");
    bb({8'h06, 56'h0}, 8);
    chk1("wel2", 1'b1, wel2);
    bb({8'h9b, 16'h0000, 40'h0}, 24);
    chk1("wel2", 1'b0, wel2);
    bb({8'h06, 56'h0}, 11);
    chk1("wel2", 1'b0, wel2);
    bb({8'h06, 56'h0}, 8);
    bb({8'h9b, 24'h000000, 8'ha5, 24'h0}, 43);
    chk1("wel2", 1'b0, wel2);
    chk1("locked2", 1'b0, locked2);
    chk1("busy2", 1'b0, busy2);
    $display("test broken_frames done");
    final_report();
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    final_report();
  end
endmodule : tb_top
`default_nettype wire
